/* pca_arbiter.sv */
// Central arbiter for one PCI interface of a dual-interface bridge.
// Assumes bus pins are already synchronous to clk; frame and irdy stay active low inside.
// Notes on behaviour
// RULE_01 - Serve internal master plus four external
// RULE_02 - Extra pairs assignable to either arbiter
// RULE_03 - Ignore extra requests until assignment initialised
// RULE_04 - Single-interface part ties extras here
// RULE_05 - Two levels; low group one high slot
// RULE_06 - Per turn one low master granted
// RULE_07 - Next grant resolved during current transfer
// RULE_08 - Grant moves if no frame in 16
// RULE_09 - Idle means frame and irdy deasserted
// RULE_10 - Monitor marks slow masters non-functioning
// RULE_11 - Non-functioning masters excluded until cleared
// RULE_12 - Reset clears all non-functioning bits
// RULE_13 - Active master keeps grant whole transfer
// RULE_14 - Other grants dropped while access continues
// RULE_15 - Re-arbitrate on final data phase
// RULE_16 - Per-master priority bit, software writable
// RULE_17 - Arbiter active only when enabled
// RULE_18 - External arbiter: internal master uses pair 1 (code takes int_gnt from the ext_req_n[1] pin only; int_req is not driven out)
// RULE_19 - Park on last or selected master
// RULE_20 - Parked master drives address, command, parity
// RULE_21 - Park only once bus idle
// RULE_22 - May park on dead master until request
// RULE_23 - At most one grant at once
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
module pca_arbiter
  import pca_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Strap and variant inputs, held steady after reset
  input wire logic powerup_arbiter_enable,
  input wire logic single_interface,
  input wire logic interface_id,
  input wire logic cfg_loaded,
  input wire logic [2:0] cfg_load_owner,
  input wire logic cfg_load_pin_config,
  // Internal master request and grant, active high
  input wire logic int_req,
  output logic int_gnt,
  // External request and grant pins, active low, index 1..7 used
  input wire logic [7:1] ext_req_n,
  output logic [7:1] ext_gnt_n,
  output logic [7:1] ext_gnt_oe,
  // Bus state pins, active low
  input wire logic frame_n,
  input wire logic irdy_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // Control and status storage
  logic [12:0] ctrl_reg;
  logic [7:0] dead_reg;
  logic [7:0] dead_next;
  logic [2:0] owner_reg;
  logic pin_cfg_reg;
  logic init_reg;
  logic load_done_reg;
  logic [31:0] rdata_reg;

  // Arbitration state
  pca_state_type state_reg;
  pca_state_type state_next;
  logic [2:0] gnt_idx_reg;
  logic [2:0] gnt_idx_next;
  logic gnt_on_reg;
  logic gnt_on_next;
  logic [2:0] last_hi_reg;
  logic [2:0] last_lo_reg;
  logic [4:0] wait_cnt_reg;
  logic [2:0] last_master_reg;

  // Field views of control
  wire logic [7:0] master_priority_level = ctrl_reg[CTRL_PRI_LSB +: 8];
  wire logic [2:0] park_target_sel = ctrl_reg[CTRL_PARK_SEL_LSB +: 3];
  wire logic park_last_mode = ctrl_reg[CTRL_PARK_MODE_BIT];
  wire logic monitor_en = ctrl_reg[CTRL_MON_EN_BIT];
  wire logic [2:0] extra_pair_owner_sel = owner_reg;
  wire logic extra_pin_config = pin_cfg_reg;

  // Bus condition decode
  wire logic bus_idle = frame_n && irdy_n; // RULE_09
  wire logic last_phase = frame_n && !irdy_n; // RULE_15
  wire logic frame_start = !frame_n;

  // Extra pair ownership: all pairs in single-interface parts; with pin config set, pair belongs here if owner bit equals our id; else all to id 0
  wire logic [2:0] extra_mine;
  assign extra_mine = single_interface ? 3'h7 : // RULE_04
    (extra_pin_config ? ~(extra_pair_owner_sel ^ {3{interface_id}}) // RULE_02
     : {3{~interface_id}});

  // Raw requests, internal master on slot 0, extras gated by init
  wire logic [7:0] raw_req;
  assign raw_req[0] = int_req; // RULE_01
  assign raw_req[4:1] = ~ext_req_n[4:1]; // RULE_01
  assign raw_req[7:5] = ~ext_req_n[7:5] & extra_mine & {3{init_reg}}; // RULE_03

  // Dead masters excluded from the contest
  wire logic [7:0] live_req = raw_req & ~dead_reg; // RULE_11
  wire logic any_req = |live_req;

  // Two level split
  wire logic [7:0] hi_req = live_req & ~master_priority_level; // RULE_16
  wire logic [7:0] lo_req = live_req & master_priority_level; // RULE_16

  // Pickers: one per level; the low group takes its turn through a token, not a high-level slot
  pca_rr_if hi_rr ();
  pca_rr_if lo_rr ();
  assign hi_rr.req = hi_req;
  assign hi_rr.last = last_hi_reg;
  assign lo_rr.req = lo_req;
  assign lo_rr.last = last_lo_reg;

  pca_rr_pick u_hi (
    .rr(hi_rr.picker)
  );
  pca_rr_pick u_lo (
    .rr(lo_rr.picker)
  );

  // Low group token: set after the high lap wraps past slot 7
  logic lo_turn_reg;
  wire logic hi_wrap = hi_rr.found && (hi_rr.pick <= last_hi_reg);
  // Token, or no high request: a lap that wraps earns the low group one later slot
  wire logic take_lo = lo_rr.found && (lo_turn_reg || !hi_rr.found); // RULE_05 RULE_06
  wire logic [2:0] win_idx = take_lo ? lo_rr.pick : hi_rr.pick;

  // Park target when nobody asks
  wire logic [2:0] park_idx = park_last_mode ? last_master_reg
    : park_target_sel; // RULE_19

  // Grant response timeout
  wire logic timeout = (state_reg == ST_WAIT) &&
    (wait_cnt_reg >= GNT_RESP_LIMIT - 5'h1) && bus_idle; // RULE_08

  // Non-functioning bookkeeping: hardware set wins over software clear
  wire logic clr_dead = reg_wr && (reg_addr == ADDR_STATUS);
  always_comb begin
    dead_next = dead_reg;
    if (clr_dead) begin
      dead_next = dead_reg & ~reg_wdata[7:0]; // RULE_11
    end
    if (timeout && monitor_en && gnt_on_reg && raw_req[gnt_idx_reg]) begin
      dead_next[gnt_idx_reg] = 1'b1; // RULE_10
    end
  end

  // Arbitration step, decision made ahead of the bus going idle
  always_comb begin
    state_next = state_reg;
    gnt_idx_next = gnt_idx_reg;
    gnt_on_next = gnt_on_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (frame_start && gnt_on_reg) begin
          state_next = ST_BUSY;
        end else if (any_req && (!gnt_on_reg || !live_req[gnt_idx_reg]
            || dead_reg[gnt_idx_reg])) begin
          gnt_idx_next = win_idx; // RULE_07 RULE_22
          gnt_on_next = 1'b1;
          state_next = ST_WAIT;
        end else if (!any_req && bus_idle) begin
          gnt_idx_next = park_idx; // RULE_21 RULE_20
          gnt_on_next = 1'b1;
        end
      end
      ST_WAIT: begin
        if (frame_start) begin
          state_next = ST_BUSY;
        end else if (timeout) begin
          gnt_on_next = 1'b0; // RULE_08
          state_next = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (last_phase && any_req) begin
          gnt_idx_next = win_idx; // RULE_15
          gnt_on_next = 1'b1;
          state_next = ST_WAIT;
        end else if (bus_idle) begin
          state_next = ST_IDLE; // RULE_21
        end else if (any_req) begin
          gnt_idx_next = gnt_idx_reg; // RULE_13 RULE_14
        end
      end
      default: begin
        state_next = ST_IDLE;
        gnt_on_next = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      gnt_idx_reg <= MST_INTERNAL;
      gnt_on_reg <= 1'b0;
      wait_cnt_reg <= 5'h0;
    end else begin
      state_reg <= state_next;
      gnt_idx_reg <= gnt_idx_next;
      gnt_on_reg <= gnt_on_next;
      wait_cnt_reg <= (state_next == ST_WAIT && state_reg == ST_WAIT)
        ? wait_cnt_reg + 5'h1 : 5'h0;
    end
  end

  // Round-robin history, advanced on each arbitrated grant; parking leaves it
  wire logic new_grant = (state_next == ST_WAIT) && (state_reg != ST_WAIT);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_hi_reg <= 3'h7;
      last_lo_reg <= 3'h7;
      lo_turn_reg <= 1'b0;
      last_master_reg <= MST_INTERNAL;
    end else if (new_grant) begin
      last_master_reg <= win_idx;
      if (take_lo) begin
        last_lo_reg <= lo_rr.pick; // RULE_06
        lo_turn_reg <= 1'b0;
      end else begin
        last_hi_reg <= hi_rr.pick;
        lo_turn_reg <= lo_turn_reg | hi_wrap; // RULE_05
      end
    end
  end

  // Dead flags, cleared at reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dead_reg <= 8'h00; // RULE_12
    end else begin
      dead_reg <= dead_next;
    end
  end

  // Control register writes
  wire logic wr_ctrl = reg_wr && (reg_addr == ADDR_ARB_CTRL);
  wire logic wr_xcfg = reg_wr && (reg_addr == ADDR_EXTRA_CFG);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata[12:0]; // RULE_16 RULE_19
    end
  end

  // Extra pair assignment: reset-time load or software write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owner_reg <= 3'h0;
      pin_cfg_reg <= 1'b0;
      init_reg <= 1'b0;
      load_done_reg <= 1'b0;
    end else if (wr_xcfg) begin
      owner_reg <= reg_wdata[XCFG_OWNER_LSB +: 3];
      pin_cfg_reg <= reg_wdata[XCFG_PIN_CFG_BIT];
      init_reg <= 1'b1; // RULE_03
    end else if (cfg_loaded && !load_done_reg) begin
      owner_reg <= cfg_load_owner;
      pin_cfg_reg <= cfg_load_pin_config;
      init_reg <= 1'b1; // RULE_03
      load_done_reg <= 1'b1;
    end
  end

  // Read mux, data valid the cycle after the strobe
  wire logic [31:0] rd_mux =
    (reg_addr == ADDR_ARB_CTRL) ? {19'h0, ctrl_reg} :
    (reg_addr == ADDR_STATUS) ? {24'h0, dead_reg} :
    (reg_addr == ADDR_EXTRA_CFG) ?
      {27'h0, init_reg, pin_cfg_reg, owner_reg} :
    (reg_addr == ADDR_GRANT) ?
      {27'h0, state_reg == ST_BUSY, gnt_on_reg, gnt_idx_reg} : 32'h0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = rdata_reg;

  // One-hot grant from a single index keeps grants exclusive
  wire logic [7:0] gnt_hot = gnt_on_reg ? (8'h01 << gnt_idx_reg) : 8'h00;

  // Pin drive: with the arbiter off, the pair 1 request pin carries the internal grant
  assign int_gnt = powerup_arbiter_enable ? gnt_hot[0] // RULE_17 RULE_23
    : !ext_req_n[1]; // RULE_18
  assign ext_gnt_n[1] = powerup_arbiter_enable ? !gnt_hot[1] : 1'b1;
  assign ext_gnt_n[7:2] = powerup_arbiter_enable ? ~gnt_hot[7:2] // RULE_23
    : 6'h3f;
  assign ext_gnt_oe[1] = powerup_arbiter_enable;
  assign ext_gnt_oe[4:2] = {3{powerup_arbiter_enable}}; // RULE_17
  assign ext_gnt_oe[7:5] = {3{powerup_arbiter_enable}} & extra_mine;

endmodule // pca_arbiter

/* pca_arbiter_chk.sv */
// Checker on the grant outputs and read port of the arbiter.
// Assumes binding into pca_arbiter; sees its ports only.
`timescale 1ns/100ps
module pca_arbiter_chk
  import pca_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Straps
  input wire logic powerup_arbiter_enable,
  input wire logic cfg_loaded,
  // Requests, grants and bus
  input wire logic int_req,
  input wire logic int_gnt,
  input wire logic [7:1] ext_req_n,
  input wire logic [7:1] ext_gnt_n,
  input wire logic [7:1] ext_gnt_oe,
  input wire logic frame_n,
  input wire logic irdy_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] gnt_q;
  logic [4:0] wait_cnt;
  logic init_seen;
  // Grant vector, index 0 the internal master
  wire logic [7:0] gnt_vec = {~ext_gnt_n, int_gnt};
  wire logic gnt_req = |(~ext_gnt_n & ~ext_req_n) | (int_gnt & int_req);
  wire logic bus_idle = frame_n & irdy_n;
  wire logic cfg_wr = reg_wr && reg_addr == ADDR_EXTRA_CFG;

  // Idle cycles a requesting grantee sits unframed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gnt_q <= 8'h00;
      wait_cnt <= 5'h00;
      init_seen <= 1'b0;
    end else begin
      gnt_q <= gnt_vec;
      wait_cnt <= (bus_idle && gnt_req && gnt_vec == gnt_q) ?
                  wait_cnt + 5'h01 : 5'h00;
      init_seen <= init_seen | cfg_loaded | cfg_wr;
    end
  end

  sequence last_phase;
    frame_n && !irdy_n;
  endsequence
  sequence no_req;
    &ext_req_n && !int_req;
  endsequence

  one_grant_a: assert property ($onehot0(gnt_vec))
    else $error("more than one grant");
  hold_busy_a: assert property (!frame_n |=> $stable(gnt_vec))
    else $error("grant moved during a transfer");
  park_wait_a: assert property (last_phase ##0 no_req |=> $stable(gnt_vec))
    else $error("parked before the bus went idle");
  resp_limit_a: assert property (wait_cnt <= 5'd17)
    else $error("unframed grant held too long");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  oe_on_a: assert property (powerup_arbiter_enable |-> &ext_gnt_oe[4:1])
    else $error("grant pin not driven");
  ext_mirror_a: assert property (!powerup_arbiter_enable |-> int_gnt == !ext_req_n[1])
    else $error("internal grant not from pair one");
  extra_hold_a: assert property (!init_seen |-> &ext_gnt_n[7:5])
    else $error("extra pair granted before init");
endmodule // pca_arbiter_chk

bind pca_arbiter pca_arbiter_chk pca_arbiter_chk_inst (.clk(clk), .rstn(rstn),
  .powerup_arbiter_enable(powerup_arbiter_enable), .cfg_loaded(cfg_loaded),
  .int_req(int_req), .int_gnt(int_gnt), .ext_req_n(ext_req_n),
  .ext_gnt_n(ext_gnt_n), .ext_gnt_oe(ext_gnt_oe), .frame_n(frame_n),
  .irdy_n(irdy_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

/* pca_master_model.sv */
// Model of the PCI masters on the far side of the arbiter.
// Assumes one shared frame/irdy pair, sampled on clk.
`timescale 1ns/100ps
module pca_master_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Who wants the bus, and who never frames
  input wire logic [7:0] want,
  input wire logic [7:0] slow,
  // Arbiter side
  input wire logic int_gnt,
  output logic int_req,
  input wire logic [7:1] ext_gnt_n,
  output logic [7:1] ext_req_n,
  output logic frame_n,
  output logic irdy_n
);
  logic [1:0] phase_reg;
  wire logic [7:0] gnt_vec = {~ext_gnt_n, int_gnt};
  // A slow master sits on its grant, so the monitor can time it out
  wire logic start = |(gnt_vec & want & ~slow) && phase_reg == 2'h0;
  assign int_req = want[0];
  assign ext_req_n = ~want[7:1];

  // Three-phase transfer, then one idle cycle for turnaround
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 2'h0;
      frame_n <= 1'b1;
      irdy_n <= 1'b1;
    end else begin
      case (phase_reg)
        2'h0: if (start) begin
          frame_n <= 1'b0;
          irdy_n <= 1'b0;
          phase_reg <= 2'h3;
        end
        2'h3: phase_reg <= 2'h2;
        2'h2: begin
          frame_n <= 1'b1; // Last data phase
          phase_reg <= 2'h1;
        end
        default: begin
          irdy_n <= 1'b1; // Pull-up takes both lines high
          phase_reg <= 2'h0;
        end
      endcase
    end
  end
endmodule // pca_master_model

/* pca_pkg.sv */
// Package for the PCI central arbiter: register map, field positions,
// reset values, master numbering and timing counts.
// Assumes a 20 MHz PCI clock domain and a one-cycle register port.
package pca_pkg;

  // Master numbering: 0 internal master, 1..4 external, 5..7 extra pairs
  localparam int unsigned NUM_MASTERS = 8;
  localparam logic [2:0] MST_INTERNAL = 3'h0;
  localparam logic [2:0] MST_EXTRA_FIRST = 3'h5;

  // Register offsets (word index on the plain port)
  localparam logic [3:0] ADDR_ARB_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_EXTRA_CFG = 4'h2;
  localparam logic [3:0] ADDR_GRANT = 4'h3;

  // Arbiter control register fields
  localparam int unsigned CTRL_PRI_LSB = 0;  // Eight priority bits
  localparam int unsigned CTRL_PARK_SEL_LSB = 8;  // Three bits
  localparam int unsigned CTRL_PARK_MODE_BIT = 11;
  localparam int unsigned CTRL_MON_EN_BIT = 12;
  localparam logic [12:0] CTRL_RESET = 13'h0800;

  // Extra pin configuration register fields
  localparam int unsigned XCFG_OWNER_LSB = 0;  // Three owner bits
  localparam int unsigned XCFG_PIN_CFG_BIT = 3;
  localparam int unsigned XCFG_INIT_BIT = 4;  // Read only

  // Grant response timing
  localparam int unsigned GNT_RESP_CLOCKS = 16;
  localparam logic [4:0] GNT_RESP_LIMIT = 5'(GNT_RESP_CLOCKS);

  // Arbiter states, Gray coded along idle, grant, busy
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BUSY = 2'b11
  } pca_state_type;

endpackage

/* pca_rr_if.sv */
// Interface carrying one round-robin pick between the arbiter modules.
// Assumes both ends are in the PCI clock domain.
`timescale 1ns/100ps
interface pca_rr_if;
  logic [7:0] req;
  logic [2:0] last;
  logic found;
  logic [2:0] pick;
  modport picker (input req, input last, output found, output pick);
  modport user (output req, output last, input found, input pick);
endinterface

/* pca_rr_pick.sv */
// Round-robin picker over eight request lines.
// Assumes the caller holds the last winner; purely combinational.
`timescale 1ns/100ps
module pca_rr_pick
  import pca_pkg::*;
(
  // Pick request
  pca_rr_if.picker rr
);

  // Search upward from the slot after the last winner
  always_comb begin
    logic [2:0] idx;
    rr.found = 1'b0;
    rr.pick = 3'h0;
    idx = 3'h0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(rr.last + 3'(i));
      if (!rr.found && rr.req[idx]) begin
        rr.found = 1'b1;
        rr.pick = idx;
      end
    end
  end

endmodule // pca_rr_pick

/* tb_pca_arbiter.sv */
// Testbench for the arbiter, with a model of its masters.
// Assumes a 20 MHz clock and the one-cycle register port.
`timescale 1ns/100ps
module tb_pca_arbiter;
  import pca_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic powerup_arbiter_enable = 1'b1;
  logic [7:0] want = 8'h00;
  logic [7:0] slow = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic frame_q = 1'b1;
  logic int_req, int_gnt, frame_n, irdy_n;
  logic [7:1] ext_req_n, ext_gnt_n, ext_gnt_oe;
  logic [31:0] reg_rdata;
  int mismatches = 0;
  int n_tests = 0;
  int starts [8];
  int base [8];
  int g4 = 0;
  int g4_base = 0;
  int cyc = 0;
  wire logic [7:0] gnt_vec = {~ext_gnt_n, int_gnt};

  always #25 clk = ~clk;

  pca_arbiter pca_arbiter_inst (.clk(clk), .rstn(rstn),
    .powerup_arbiter_enable(powerup_arbiter_enable),
    .single_interface(1'b0), .interface_id(1'b0), .cfg_loaded(1'b0),
    .cfg_load_owner(3'h0), .cfg_load_pin_config(1'b0),
    .int_req(int_req), .int_gnt(int_gnt), .ext_req_n(ext_req_n),
    .ext_gnt_n(ext_gnt_n), .ext_gnt_oe(ext_gnt_oe), .frame_n(frame_n),
    .irdy_n(irdy_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pca_master_model pca_master_model_inst (.clk(clk), .rstn(rstn),
    .want(want), .slow(slow), .int_gnt(int_gnt), .int_req(int_req),
    .ext_gnt_n(ext_gnt_n), .ext_req_n(ext_req_n), .frame_n(frame_n),
    .irdy_n(irdy_n));

  // Frame starts per grantee, and cycles master 4 held a grant
  always @(posedge clk) begin
    frame_q <= frame_n;
    if (!ext_gnt_n[4]) g4 <= g4 + 1;
    for (int i = 0; i < 8; i++)
      if (frame_q && !frame_n && gnt_vec[i]) starts[i] <= starts[i] + 1;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    run(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    run(1);
    reg_rd <= 1'b0;
    check(reg_rdata, exp);
  endtask
  // Bounded wait for n new frame starts, cycles taken in cyc
  task automatic wait_starts(input int n);
    for (cyc = 0; cyc < 300 && starts.sum() - base.sum() < n; cyc++) run(1);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is under a thousand cycles
  initial begin
    run(3000);
    mismatches++;
    wrap_up();
  end

  initial begin
    run(3);
    rstn <= 1'b1;
    run(2);
    rd(ADDR_ARB_CTRL, 32'(CTRL_RESET));
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_EXTRA_CFG, 32'h0);
    rd(4'hc, 32'h0);
    want <= 8'h04;
    run(30);
    want <= 8'h01;
    base = starts;
    run(30);
    check(ext_gnt_n, 7'h7f);
    check(starts[0] > base[0], 1);
    want <= 8'h00;
    run(20);
    check(int_gnt, 1'b1);
    // Masters 3 and 4 low, 1 high: low pair shares one slot
    wr(ADDR_ARB_CTRL, 32'h0818);
    want <= 8'h1a;
    run(30);
    base = starts;
    wait_starts(4);
    check(starts[1] - base[1], 2);
    check(starts[3] - base[3], 1);
    check(starts[4] - base[4], 1);
    check(cyc <= 17, 1);
    // Master 4 never frames while the monitor is on
    wr(ADDR_ARB_CTRL, 32'h1800);
    slow <= 8'h10;
    want <= 8'h14;
    base = starts;
    run(100);
    check(starts[2] > base[2], 1);
    rd(ADDR_STATUS, 32'h10);
    g4_base = g4;
    run(60);
    check(g4 - g4_base, 0);
    wr(ADDR_STATUS, 32'h10);
    rd(ADDR_STATUS, 32'h0);
    // Extra pair ignored until the extra pin configuration register is written
    slow <= 8'h00;
    want <= 8'h20;
    base = starts;
    run(40);
    check(starts[5] - base[5], 0);
    wr(ADDR_EXTRA_CFG, 32'h8);
    rd(ADDR_EXTRA_CFG, 32'h18);
    run(30);
    check(starts[5] > base[5], 1);
    check(ext_gnt_oe[5], 1'b1);
    want <= 8'h00;
    wr(ADDR_ARB_CTRL, 32'h0300);
    run(30);
    check(ext_gnt_n, 7'h7b);
    // Strapped to an outside arbiter: pair 1 carries our grant
    powerup_arbiter_enable <= 1'b0;
    rstn <= 1'b0;
    run(3);
    rstn <= 1'b1;
    want <= 8'h02;
    run(2);
    check(int_gnt, 1'b1);
    wrap_up();
  end
endmodule // tb_pca_arbiter
